// file: pkg/brt_pkg.sv
// bit-rate and hold-timing package: register map, field layout, timing types
// assumes a byte-wide register port and a single 200 MHz bus clock
package brt_pkg;

    // register offsets on the plain register port
    localparam logic [7:0] BRT_CFG_OFS    = 8'h00;
    localparam logic [7:0] BRT_CTRL_OFS   = 8'h01;
    localparam logic [7:0] BRT_STATUS_OFS = 8'h02;

    // bit_rate_config field layout
    localparam int BRT_RATE_MULTIPLIER_HI = 7;
    localparam int BRT_RATE_MULTIPLIER_LO = 6;
    localparam int BRT_CODE_HI = 5;
    localparam int BRT_CODE_LO = 0;

    // control register: module_enable_bit position
    localparam int BRT_EN_BIT = 7;

    // status register bit positions
    localparam int BRT_ST_SCL   = 0;
    localparam int BRT_ST_SDAH  = 1;
    localparam int BRT_ST_STAH  = 2;
    localparam int BRT_ST_STOH  = 3;
    localparam int BRT_ST_EN    = 7;

    // reset values
    localparam logic [7:0] BRT_CFG_RST  = 8'h00;
    localparam logic [7:0] BRT_CTRL_RST = 8'h00;

    // rate_multiplier encodings
    localparam logic [1:0] BRT_MUL1 = 2'h0;
    localparam logic [1:0] BRT_MUL2 = 2'h1;
    localparam logic [1:0] BRT_MUL4 = 2'h2;

    // width of every scaled cycle count (4 x 3840 fits)
    localparam int BRT_CW = 14;

    // timing set selected by one clock_rate_code
    typedef struct packed {
        logic [11:0] scl_div;
        logic [9:0]  sda_hold;
        logic [10:0] start_hold;
        logic [10:0] stop_hold;
    } brt_timing_t;

    // register port request as it arrives from software
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } brt_req_t;

endpackage

// file: core/brt_hold_timer.sv
// one-shot cycle timer used for every hold delay
// assumes count_i is stable in the start cycle and is at least 1
`timescale 1ns/100ps

module brt_hold_timer
(
    input  wire logic                       clock_i,
    input  wire logic                       rst_n_i,
    input  wire logic                       clear_i,
    input  wire logic                       start_i,
    input  wire logic [brt_pkg::BRT_CW-1:0] count_i,
    output logic                            busy_o,
    output logic                            done_o
);
    import brt_pkg::*;

    logic [BRT_CW-1:0] cnt_r;
    logic [BRT_CW-1:0] cnt_nxt;
    logic              busy_r;
    logic              busy_nxt;
    logic              done_r;
    logic              done_nxt;

    // done pulses exactly count_i cycles after the start cycle
    always_comb
    begin
        cnt_nxt  = cnt_r;
        busy_nxt = busy_r;
        done_nxt = 1'b0;
        if (clear_i)
        begin
            cnt_nxt  = '0;
            busy_nxt = 1'b0;
        end
        else if (start_i)
        begin
            cnt_nxt  = count_i - BRT_CW'(1);
            busy_nxt = (count_i > BRT_CW'(1));
            done_nxt = (count_i == BRT_CW'(1));
        end
        else if (busy_r)
        begin
            cnt_nxt  = cnt_r - BRT_CW'(1);
            busy_nxt = (cnt_r > BRT_CW'(1));
            done_nxt = (cnt_r == BRT_CW'(1));
        end
    end

    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            cnt_r  <= '0;
            busy_r <= 1'b0;
            done_r <= 1'b0;
        end
        else
        begin
            cnt_r  <= cnt_nxt;
            busy_r <= busy_nxt;
            done_r <= done_nxt;
        end
    end

    assign busy_o = busy_r;
    assign done_o = done_r;

endmodule

// file: core/brt_top.sv
// bit-rate and hold-timing generator of a two-wire serial bus controller
// assumes the byte engine drives run/start/stop strobes on clock_i
//
// The placing of the registers and strobed register access were left to the implementer.
`timescale 1ns/100ps

module brt_top
(
    input  wire logic       clock_i,
    input  wire logic       resetn_i,
    input  wire logic [7:0] reg_addr_i,
    input  wire logic [7:0] reg_wdata_i,
    input  wire logic       reg_wr_i,
    input  wire logic       reg_rd_i,
    output logic [7:0]      reg_rdata_o,
    input  wire logic       scl_run_i,
    input  wire logic       start_sda_fell_i,
    input  wire logic       stop_scl_rose_i,
    output logic            scl_o,
    output logic            scl_fall_o,
    output logic            sda_change_o,
    output logic            start_scl_low_o,
    output logic            stop_sda_release_o
);
    import brt_pkg::*;

    // constant table of divider and hold values for all 64 codes
    function automatic brt_timing_t brt_lookup(input logic [5:0] code);
        brt_timing_t t;
        t = '0;
        unique case (code)
            6'h00: t = '{12'd20, 10'd7, 11'd6, 11'd11};
            6'h01: t = '{12'd22, 10'd7, 11'd7, 11'd12};
            6'h02: t = '{12'd24, 10'd8, 11'd8, 11'd13};
            6'h03: t = '{12'd26, 10'd8, 11'd9, 11'd14};
            6'h04: t = '{12'd28, 10'd9, 11'd10, 11'd15};
            6'h05: t = '{12'd30, 10'd9, 11'd11, 11'd16};
            6'h06: t = '{12'd34, 10'd10, 11'd13, 11'd18};
            6'h07: t = '{12'd40, 10'd10, 11'd16, 11'd21};
            6'h08: t = '{12'd28, 10'd7, 11'd10, 11'd15};
            6'h09: t = '{12'd32, 10'd7, 11'd12, 11'd17};
            6'h0A: t = '{12'd36, 10'd9, 11'd14, 11'd19};
            6'h0B: t = '{12'd40, 10'd9, 11'd16, 11'd21};
            6'h0C: t = '{12'd44, 10'd11, 11'd18, 11'd23};
            6'h0D: t = '{12'd48, 10'd11, 11'd20, 11'd25};
            6'h0E: t = '{12'd56, 10'd13, 11'd24, 11'd29};
            6'h0F: t = '{12'd68, 10'd13, 11'd30, 11'd35};
            6'h10: t = '{12'd48, 10'd9, 11'd18, 11'd25};
            6'h11: t = '{12'd56, 10'd9, 11'd22, 11'd29};
            6'h12: t = '{12'd64, 10'd13, 11'd26, 11'd33};
            6'h13: t = '{12'd72, 10'd13, 11'd30, 11'd37};
            6'h14: t = '{12'd80, 10'd17, 11'd34, 11'd41};
            6'h15: t = '{12'd88, 10'd17, 11'd38, 11'd45};
            6'h16: t = '{12'd104, 10'd21, 11'd46, 11'd53};
            6'h17: t = '{12'd128, 10'd21, 11'd58, 11'd65};
            6'h18: t = '{12'd80, 10'd9, 11'd38, 11'd41};
            6'h19: t = '{12'd96, 10'd9, 11'd46, 11'd49};
            6'h1A: t = '{12'd112, 10'd17, 11'd54, 11'd57};
            6'h1B: t = '{12'd128, 10'd17, 11'd62, 11'd65};
            6'h1C: t = '{12'd144, 10'd25, 11'd70, 11'd73};
            6'h1D: t = '{12'd160, 10'd25, 11'd78, 11'd81};
            6'h1E: t = '{12'd192, 10'd33, 11'd94, 11'd97};
            6'h1F: t = '{12'd240, 10'd33, 11'd118, 11'd121};
            6'h20: t = '{12'd160, 10'd17, 11'd78, 11'd81};
            6'h21: t = '{12'd192, 10'd17, 11'd94, 11'd97};
            6'h22: t = '{12'd224, 10'd33, 11'd110, 11'd113};
            6'h23: t = '{12'd256, 10'd33, 11'd126, 11'd129};
            6'h24: t = '{12'd288, 10'd49, 11'd142, 11'd145};
            6'h25: t = '{12'd320, 10'd49, 11'd158, 11'd161};
            6'h26: t = '{12'd384, 10'd65, 11'd190, 11'd193};
            6'h27: t = '{12'd480, 10'd65, 11'd238, 11'd241};
            6'h28: t = '{12'd320, 10'd33, 11'd158, 11'd161};
            6'h29: t = '{12'd384, 10'd33, 11'd190, 11'd193};
            6'h2A: t = '{12'd448, 10'd65, 11'd222, 11'd225};
            6'h2B: t = '{12'd512, 10'd65, 11'd254, 11'd257};
            6'h2C: t = '{12'd576, 10'd97, 11'd286, 11'd289};
            6'h2D: t = '{12'd640, 10'd97, 11'd318, 11'd321};
            6'h2E: t = '{12'd768, 10'd129, 11'd382, 11'd385};
            6'h2F: t = '{12'd960, 10'd129, 11'd478, 11'd481};
            6'h30: t = '{12'd640, 10'd65, 11'd318, 11'd321};
            6'h31: t = '{12'd768, 10'd65, 11'd382, 11'd385};
            6'h32: t = '{12'd896, 10'd129, 11'd446, 11'd449};
            6'h33: t = '{12'd1024, 10'd129, 11'd510, 11'd513};
            6'h34: t = '{12'd1152, 10'd193, 11'd574, 11'd577};
            6'h35: t = '{12'd1280, 10'd193, 11'd638, 11'd641};
            6'h36: t = '{12'd1536, 10'd257, 11'd766, 11'd769};
            6'h37: t = '{12'd1920, 10'd257, 11'd958, 11'd961};
            6'h38: t = '{12'd1280, 10'd129, 11'd638, 11'd641};
            6'h39: t = '{12'd1536, 10'd129, 11'd766, 11'd769};
            6'h3A: t = '{12'd1792, 10'd257, 11'd894, 11'd897};
            6'h3B: t = '{12'd2048, 10'd257, 11'd1022, 11'd1025};
            6'h3C: t = '{12'd2304, 10'd385, 11'd1150, 11'd1153};
            6'h3D: t = '{12'd2560, 10'd385, 11'd1278, 11'd1281};
            6'h3E: t = '{12'd3072, 10'd513, 11'd1534, 11'd1537};
            6'h3F: t = '{12'd3840, 10'd513, 11'd1918, 11'd1921};
        endcase
        return t;
    endfunction

    // scale a table value by the multiplier; reserved code acts as x1
    function automatic logic [BRT_CW-1:0] brt_scale(input logic [11:0] v,
                                                    input logic [1:0]  m);
        logic [BRT_CW-1:0] w;
        w = BRT_CW'(v);
        unique case (m)
            BRT_MUL2: brt_scale = w << 1;
            BRT_MUL4: brt_scale = w << 2;
            default:  brt_scale = w;
        endcase
    endfunction

    logic              rst_sync1_r;
    logic              rst_sync2_r;
    logic              rst_n;
    brt_req_t          req;
    logic [7:0]        cfg_r;
    logic [7:0]        cfg_nxt;
    logic [7:0]        ctrl_r;
    logic [7:0]        ctrl_nxt;
    logic [7:0]        rdata_r;
    logic [7:0]        rdata_nxt;
    logic              enable;
    brt_timing_t       tm;
    logic [BRT_CW-1:0] half_cnt;
    logic [BRT_CW-1:0] sda_cnt;
    logic [BRT_CW-1:0] start_cnt;
    logic [BRT_CW-1:0] stop_cnt;
    logic [BRT_CW-1:0] scl_cnt_r;
    logic [BRT_CW-1:0] scl_cnt_nxt;
    logic              scl_r;
    logic              scl_nxt;
    logic              fall_r;
    logic              fall_nxt;
    logic              sda_busy;
    logic              start_busy;
    logic              stop_busy;

    // reset released through two flops; asserts at once
    always_ff @(posedge clock_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            rst_sync1_r <= 1'b0;
            rst_sync2_r <= 1'b0;
        end
        else
        begin
            rst_sync1_r <= 1'b1;
            rst_sync2_r <= rst_sync1_r;
        end
    end
    assign rst_n = rst_sync2_r;

    assign req = '{reg_addr_i, reg_wdata_i, reg_wr_i, reg_rd_i};

    // decode from the live register so a rewrite takes effect next cycle
    assign enable    = ctrl_r[BRT_EN_BIT];
    assign tm        = brt_lookup(cfg_r[BRT_CODE_HI:BRT_CODE_LO]);
    assign half_cnt  = brt_scale(tm.scl_div, cfg_r[BRT_RATE_MULTIPLIER_HI:BRT_RATE_MULTIPLIER_LO]) >> 1;
    assign sda_cnt   = brt_scale(12'(tm.sda_hold), cfg_r[BRT_RATE_MULTIPLIER_HI:BRT_RATE_MULTIPLIER_LO]);
    assign start_cnt = brt_scale(12'(tm.start_hold), cfg_r[BRT_RATE_MULTIPLIER_HI:BRT_RATE_MULTIPLIER_LO]);
    assign stop_cnt  = brt_scale(12'(tm.stop_hold), cfg_r[BRT_RATE_MULTIPLIER_HI:BRT_RATE_MULTIPLIER_LO]);

    // register writes and one-cycle-late read data
    always_comb
    begin
        cfg_nxt   = cfg_r;
        ctrl_nxt  = ctrl_r;
        rdata_nxt = 8'h00;
        if (req.wr)
        begin
            if (req.addr == BRT_CFG_OFS)
                cfg_nxt = req.wdata;
            if (req.addr == BRT_CTRL_OFS)
                ctrl_nxt = req.wdata & (8'h01 << BRT_EN_BIT);
        end
        if (req.rd)
        begin
            unique case (req.addr)
                BRT_CFG_OFS:    rdata_nxt = cfg_r;
                BRT_CTRL_OFS:   rdata_nxt = ctrl_r;
                BRT_STATUS_OFS:
                begin
                    rdata_nxt[BRT_ST_SCL]  = scl_r;
                    rdata_nxt[BRT_ST_SDAH] = sda_busy;
                    rdata_nxt[BRT_ST_STAH] = start_busy;
                    rdata_nxt[BRT_ST_STOH] = stop_busy;
                    rdata_nxt[BRT_ST_EN]   = enable;
                end
                default:        rdata_nxt = 8'h00; // unmapped reads zero
            endcase
        end
    end

    always_ff @(posedge clock_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cfg_r   <= BRT_CFG_RST;
            ctrl_r  <= BRT_CTRL_RST;
            rdata_r <= 8'h00;
        end
        else
        begin
            cfg_r   <= cfg_nxt;
            ctrl_r  <= ctrl_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    // scl generator: each half period is half of mul x divider cycles
    always_comb
    begin
        scl_cnt_nxt = scl_cnt_r;
        scl_nxt     = scl_r;
        fall_nxt    = 1'b0;
        if (!enable || !scl_run_i)
        begin
            scl_cnt_nxt = half_cnt - BRT_CW'(1);
            scl_nxt     = 1'b1; // idle bus keeps scl released high
        end
        else if (scl_cnt_r == '0)
        begin
            scl_cnt_nxt = half_cnt - BRT_CW'(1);
            scl_nxt     = !scl_r;
            fall_nxt    = scl_r;
        end
        else
            scl_cnt_nxt = scl_cnt_r - BRT_CW'(1);
    end

    always_ff @(posedge clock_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            scl_cnt_r <= '0;
            scl_r     <= 1'b1;
            fall_r    <= 1'b0;
        end
        else
        begin
            scl_cnt_r <= scl_cnt_nxt;
            scl_r     <= scl_nxt;
            fall_r    <= fall_nxt;
        end
    end

    // sda hold runs from our own scl falling edge
    brt_hold_timer u_sda_hold
    (
        .clock_i (clock_i),
        .rst_n_i (rst_n),
        .clear_i (!enable),
        .start_i (fall_r && enable),
        .count_i (sda_cnt),
        .busy_o  (sda_busy),
        .done_o  (sda_change_o)
    );

    // start hold: scl stays high until this expires
    brt_hold_timer u_start_hold
    (
        .clock_i (clock_i),
        .rst_n_i (rst_n),
        .clear_i (!enable),
        .start_i (start_sda_fell_i && enable),
        .count_i (start_cnt),
        .busy_o  (start_busy),
        .done_o  (start_scl_low_o)
    );

    // stop hold: sda released when this expires
    brt_hold_timer u_stop_hold
    (
        .clock_i (clock_i),
        .rst_n_i (rst_n),
        .clear_i (!enable),
        .start_i (stop_scl_rose_i && enable),
        .count_i (stop_cnt),
        .busy_o  (stop_busy),
        .done_o  (stop_sda_release_o)
    );

    assign reg_rdata_o = rdata_r;
    assign scl_o       = scl_r;
    assign scl_fall_o  = fall_r;

endmodule

// file: test/brt_top_assertions.sv
// checker for brt_top: read-back, SCL period and the three hold timers
// sees only brt_top ports; config and enable are shadowed from register writes
`timescale 1ns/100ps

module brt_top_assertions
(
    input  wire logic       clock_i,
    input  wire logic       resetn_i,
    input  wire logic [7:0] reg_addr_i,
    input  wire logic [7:0] reg_wdata_i,
    input  wire logic       reg_wr_i,
    input  wire logic       reg_rd_i,
    input  wire logic [7:0] reg_rdata_o,
    input  wire logic       scl_run_i,
    input  wire logic       start_sda_fell_i,
    input  wire logic       stop_scl_rose_i,
    input  wire logic       scl_o,
    input  wire logic       scl_fall_o,
    input  wire logic       sda_change_o,
    input  wire logic       start_scl_low_o,
    input  wire logic       stop_sda_release_o
);
    import brt_pkg::*;

    localparam int TA[4] = '{20, 7, 6, 11};
    localparam int TB[4] = '{240, 33, 118, 121};
    logic [7:0] cfg_r;
    logic       en_r;
    int         per_r;
    int         hold_r[3];
    logic [2:0] trg;
    logic [2:0] dne;
    logic       known;
    int         mf;
    // only codes 0x00 and 0x1F are modelled here; others are not judged
    assign known = (cfg_r[5:0] == 6'h00) || (cfg_r[5:0] == 6'h1F);
    assign mf = (cfg_r[7:6] == 2'h1) ? 2 : ((cfg_r[7:6] == 2'h2) ? 4 : 1);
    assign trg = {stop_scl_rose_i, start_sda_fell_i, scl_fall_o};
    assign dne = {stop_sda_release_o, start_scl_low_o, sda_change_o};
    function automatic int ex(input int k);
        return mf * ((cfg_r[5:0] == 6'h00) ? TA[k] : TB[k]);
    endfunction
    // cycles since each trigger, cleared on done so a later config is not judged
    always_ff @(posedge clock_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            cfg_r <= BRT_CFG_RST;
            en_r <= 1'b0;
            per_r <= 0;
            hold_r <= '{0, 0, 0};
        end
        else
        begin
            if (reg_wr_i && reg_addr_i == BRT_CFG_OFS) cfg_r <= reg_wdata_i;
            if (reg_wr_i && reg_addr_i == BRT_CTRL_OFS) en_r <= reg_wdata_i[BRT_EN_BIT];
            if (!en_r || !scl_run_i) per_r <= 0;
            else if (scl_fall_o) per_r <= 1;
            else if (per_r != 0) per_r <= per_r + 1;
            for (int i = 0; i < 3; i++)
            begin
                if (trg[i] && en_r) hold_r[i] <= 1;
                else if (dne[i] || !en_r) hold_r[i] <= 0;
                else if (hold_r[i] != 0) hold_r[i] <= hold_r[i] + 1;
            end
        end
    end
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (!resetn_i);
    sequence s_off;
        !en_r ##1 !en_r;
    endsequence
    property p_rd_cfg;
        reg_rd_i && reg_addr_i == BRT_CFG_OFS |=> reg_rdata_o == $past(cfg_r);
    endproperty
    property p_rd_idle;
        !reg_rd_i |=> reg_rdata_o == 8'h00;
    endproperty
    property p_fall;
        scl_fall_o |-> !scl_o && $past(scl_o);
    endproperty
    property p_period;
        scl_fall_o && known && per_r != 0 |-> per_r == ex(0);
    endproperty
    property p_sda;
        known && en_r |-> dne[0] == (hold_r[0] == ex(1));
    endproperty
    property p_start;
        known && en_r |-> dne[1] == (hold_r[1] == ex(2));
    endproperty
    property p_stop;
        known && en_r |-> dne[2] == (hold_r[2] == ex(3));
    endproperty
    property p_scl_idle;
        !en_r || !scl_run_i |=> scl_o;
    endproperty
    property p_quiet;
        s_off |-> dne == 3'h0;
    endproperty
    a_rd_cfg: assert property (p_rd_cfg) else $error("config read-back wrong");
    a_rd_idle: assert property (p_rd_idle) else $error("read data not zero");
    a_fall: assert property (p_fall) else $error("fall pulse off edge");
    a_period: assert property (p_period) else $error("SCL period wrong");
    a_sda: assert property (p_sda) else $error("SDA hold wrong");
    a_start: assert property (p_start) else $error("start hold wrong");
    a_stop: assert property (p_stop) else $error("stop hold wrong");
    a_scl_idle: assert property (p_scl_idle) else $error("SCL not parked high");
    a_quiet: assert property (p_quiet) else $error("timer fired disabled");
endmodule

// file: test/brt_engine_model.sv
// byte-engine model: SCL run level plus start and stop strobes
// assumes the bench calls its tasks from the same clock domain
`timescale 1ns/100ps

module brt_engine_model
(
    input  wire logic clock_i,
    output logic      scl_run_o,
    output logic      start_sda_fell_o,
    output logic      stop_scl_rose_o
);
    initial
    begin
        scl_run_o = 1'b0;
        start_sda_fell_o = 1'b0;
        stop_scl_rose_o = 1'b0;
    end
    // one-cycle strobe; returns on the edge that samples it
    task automatic send(input bit stop);
        @(posedge clock_i);
        if (stop) stop_scl_rose_o <= 1'b1;
        else start_sda_fell_o <= 1'b1;
        @(posedge clock_i);
        stop_scl_rose_o <= 1'b0;
        start_sda_fell_o <= 1'b0;
    endtask
    task automatic run(input logic on);
        @(posedge clock_i);
        scl_run_o <= on;
    endtask
endmodule

// file: test/tb_brt_top.sv
// self-checking bench for brt_top: register port, hold timers, SCL period
// assumes brt_engine_model as the byte engine and the checker bound below
`timescale 1ns/100ps

module tb_brt_top;
    import brt_pkg::*;
    logic       clock_i;
    logic       resetn_i;
    logic [7:0] reg_addr;
    logic [7:0] reg_wdata;
    logic       reg_wr;
    logic       reg_rd;
    logic [7:0] reg_rdata;
    logic       run;
    logic       sfell;
    logic       srose;
    logic       scl;
    logic       scl_fall;
    logic       sda_chg;
    logic       st_low;
    logic       sp_rel;
    int         num_errors = 0;
    int         compares = 0;
    int         cyc = 0;
    int         n;
    int         f;
    logic [7:0] cfg;
    always #2.5 clock_i = ~clock_i;
    brt_top i_brt_top (.clock_i(clock_i), .resetn_i(resetn_i), .reg_addr_i(reg_addr),
        .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_rdata_o(reg_rdata),
        .scl_run_i(run), .start_sda_fell_i(sfell), .stop_scl_rose_i(srose), .scl_o(scl),
        .scl_fall_o(scl_fall), .sda_change_o(sda_chg), .start_scl_low_o(st_low),
        .stop_sda_release_o(sp_rel));
    brt_engine_model i_brt_engine_model (.clock_i(clock_i), .scl_run_o(run),
        .start_sda_fell_o(sfell), .stop_scl_rose_o(srose));
    task automatic report_and_stop();
        if (num_errors == 0 && compares > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // hang guard, well above the longest expected run
    always @(posedge clock_i)
    begin
        cyc++;
        if (cyc == 40000)
        begin
            num_errors++;
            report_and_stop();
        end
    end
    task automatic chk8(input logic [7:0] g, input logic [7:0] e);
        compares++;
        if (g !== e)
        begin
            $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
            num_errors++;
        end
    endtask
    task automatic chkn(input int g, input int e);
        compares++;
        if (g != e)
        begin
            $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
            num_errors++;
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock_i);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clock_i);
        reg_wr <= 1'b0;
    endtask
    // read data stand only in the cycle after the strobe
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        @(posedge clock_i);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clock_i);
        reg_rd <= 1'b0;
        #1;
        chk8(reg_rdata, e);
    endtask
    function automatic logic pick(input int w);
        case (w)
            0: return sda_chg;
            1: return st_low;
            2: return sp_rel;
            default: return scl_fall;
        endcase
    endfunction
    // cycles until the picked output is seen, bounded so a hang cannot stall
    task automatic cnt_to(input int w, input int n0, output int c);
        c = n0;
        do
        begin
            @(posedge clock_i);
            #1;
            c++;
        end
        while (pick(w) !== 1'b1 && c < 5000);
    endtask
    initial
    begin
        clock_i = 1'b0;
        resetn_i = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        repeat (2) @(posedge clock_i);
        resetn_i <= 1'b1;
        repeat (3) @(posedge clock_i);
        rd_chk(BRT_CFG_OFS, BRT_CFG_RST);
        rd_chk(BRT_CTRL_OFS, BRT_CTRL_RST);
        rd_chk(BRT_STATUS_OFS, 8'h01);
        wr(8'h05, 8'hFF);
        rd_chk(8'h05, 8'h00);
        // disabled: strobe ignored and SCL parked high
        i_brt_engine_model.run(1'b1);
        i_brt_engine_model.send(1'b0);
        cnt_to(1, 1, n);
        chkn(n, 5000);
        chk8({7'h00, scl}, 8'h01);
        i_brt_engine_model.run(1'b0);
        wr(BRT_CTRL_OFS, 8'hFF);
        rd_chk(BRT_CTRL_OFS, 8'h80);
        rd_chk(BRT_STATUS_OFS, 8'h81);
        // every multiplier code against both tabulated rate codes
        for (int c = 0; c < 2; c++)
        begin
            for (int m = 0; m < 4; m++)
            begin
                cfg = {m[1:0], (c == 1) ? 6'h1F : 6'h00};
                f = (m == 1) ? 2 : ((m == 2) ? 4 : 1);
                wr(BRT_CTRL_OFS, 8'h00);
                wr(BRT_CFG_OFS, cfg);
                rd_chk(BRT_CFG_OFS, cfg);
                wr(BRT_CTRL_OFS, 8'h80);
                i_brt_engine_model.send(1'b0);
                // busy bit read mid-hold; the count resumes at the read's edge
                rd_chk(BRT_STATUS_OFS, 8'h85);
                cnt_to(1, 3, n);
                chkn(n, f * ((c == 1) ? 118 : 6));
                i_brt_engine_model.send(1'b1);
                rd_chk(BRT_STATUS_OFS, 8'h89);
                cnt_to(2, 3, n);
                chkn(n, f * ((c == 1) ? 121 : 11));
                i_brt_engine_model.run(1'b1);
                cnt_to(3, 0, n);
                // scl low and sda hold busy right after the first fall
                rd_chk(BRT_STATUS_OFS, 8'h82);
                cnt_to(3, 2, n);
                chkn(n, f * ((c == 1) ? 240 : 20));
                cnt_to(0, 0, n);
                chkn(n, f * ((c == 1) ? 33 : 7));
                i_brt_engine_model.run(1'b0);
            end
        end
        report_and_stop();
    end
endmodule

bind brt_top brt_top_assertions i_brt_top_assertions (.clock_i(clock_i),
    .resetn_i(resetn_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .scl_run_i(scl_run_i), .start_sda_fell_i(start_sda_fell_i),
    .stop_scl_rose_i(stop_scl_rose_i), .scl_o(scl_o), .scl_fall_o(scl_fall_o),
    .sda_change_o(sda_change_o), .start_scl_low_o(start_scl_low_o),
    .stop_sda_release_o(stop_sda_release_o));
